// [include/lane_link_if.sv]
// Purpose: lane frames and alignment pulse between transmitter and receiver
// Assumes: both ends on clk_sys
// Notes:   one frame of all lanes moves per valid and ready handshake
`timescale 1ns/10ps
interface lane_link_if;
   import lane_unpack_pkg::*;
   lane_t      lane_data [LANE_COUNT];
   logic       frame_valid;
   logic       frame_ready;
   logic [3:0] mf_phase;
   logic       sysref;

   modport tx (output lane_data, output frame_valid, input frame_ready, output mf_phase, output sysref);
   modport rx (input lane_data, input frame_valid, output frame_ready, input mf_phase, input sysref);
endinterface // lane_link_if

// [include/lane_unpack_pkg.sv]
// Purpose: shared constants and helpers for the lane sample packer and unpacker
// Assumes: one device clock, clk_sys, for both ends
// Notes:   a lane frame is 64 bits, nibble n at bits [63-4n -: 4]
package lane_unpack_pkg;

   // ==========================================================
   // link formats
   // ==========================================================
   localparam logic [4:0] FMT_12B_6L  = 5'h0b;
   localparam logic [4:0] FMT_12B_4L  = 5'h0c;
   localparam logic [4:0] FMT_12B_3L  = 5'h0d;
   localparam logic [4:0] FMT_8B_16L  = 5'h0e;
   localparam logic [4:0] FMT_8B_8L   = 5'h0f;
   localparam logic [4:0] FMT_8B_4L   = 5'h10;

   // ==========================================================
   // frame geometry
   // ==========================================================
   localparam int LANE_COUNT  = 16;
   localparam int LANE_BITS   = 64;
   localparam int SAMPLE_BITS = 12;
   localparam int MAX_SAMPLES = 20;
   localparam int COUNT_BITS  = 5;
   localparam int MF_FRAMES   = 16;

   // ==========================================================
   // synchronization timing; clock period in ns, delays in device-clock cycles
   // ==========================================================
   localparam int CLK_PERIOD_NS      = 40;
   localparam int SYSREF_LATENCY_X2  = 955;
   localparam int SYSREF_SYNC_CYCLES = (SYSREF_LATENCY_X2 + 1) / 2;
   localparam int LSB_PATH_BIAS      = 160;
   localparam int SYNC_COUNT_BITS    = 14;

   typedef logic [SAMPLE_BITS-1:0] sample_t;
   typedef logic [LANE_BITS-1:0]   lane_t;

   typedef enum logic [1:0] {
      SYNC_FREQ_CHANGE,
      SYNC_PHASE_CHANGE,
      SYNC_ACC_RESET
   } sync_action_t;

   // offset of the lsb path; phase picks among the listed values
   function automatic int lsb_sync_offset(input logic [8:0] factor, input logic [3:0] phase);
      int v;
      v = 0;
      unique case (factor)
         9'h002: v = -144 + 2 * int'(phase[2:0]);
         9'h003: begin
            case (phase)
               4'h0: v = -89; 4'h1: v = -86; 4'h2: v = -83; 4'h3: v = -81;
               4'h4: v = -80; 4'h5: v = -78; 4'h6: v = -77; 4'h7: v = -75;
               4'h8: v = -74; 4'h9: v = -72; 4'ha: v = -71; 4'hb: v = -69;
               4'hc: v = -68; 4'hd: v = -66; 4'he: v = -63; default: v = -60;
            endcase
         end
         9'h004: v = -36 + 4 * int'(phase[1:0]);
         9'h006: begin
            case (phase[2:0])
               3'h0: v = 34; 3'h1: v = 40; 3'h2: v = 42; 3'h3: v = 46;
               3'h4: v = 48; 3'h5: v = 52; 3'h6: v = 54; default: v = 60;
            endcase
         end
         9'h008: v = phase[0] ? 94 : 86;
         9'h00c: begin
            case (phase[1:0])
               2'h0: v = 186; 2'h1: v = 194; 2'h2: v = 198; default: v = 206;
            endcase
         end
         9'h010: v = 290;
         9'h018: v = phase[0] ? 466 : 458;
         9'h020: v = 648;
         9'h030: v = 968;
         9'h040: v = 1396;
         9'h060: v = 2036;
         9'h080: v = 2932;
         9'h0c0: v = 4212;
         9'h100: v = 6004;
         default: v = 0;
      endcase
      return v;
   endfunction

   function automatic logic [COUNT_BITS-1:0] samples_per_frame(input logic [4:0] fmt);
      unique case (fmt)
         FMT_12B_6L, FMT_12B_3L, FMT_8B_8L: return 5'h08;
         FMT_12B_4L:                        return 5'h14;
         FMT_8B_16L:                        return 5'h10;
         FMT_8B_4L:                         return 5'h04;
         default:                           return 5'h00;
      endcase
   endfunction

endpackage

// [src/lane_sample_packer.sv]
// Purpose: transmit end; samples packed into lane frames, sync marking
// Assumes: receiver decodes lsb of in-phase sample 0 as sync marker
// Notes:   one frame in flight; tx_ready returns after the frame is taken
`timescale 1ns/10ps
module lane_sample_packer
   import lane_unpack_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   rst_b,
   lane_link_if.tx                     link,
   input  wire logic [4:0]             link_format_select,
   input  wire logic [8:0]             interpolation_factor,
   input  wire logic [SAMPLE_BITS-1:0] tx_inphase    [MAX_SAMPLES],
   input  wire logic [SAMPLE_BITS-1:0] tx_quadrature [MAX_SAMPLES],
   input  wire logic                   tx_valid,
   output logic                        tx_ready,
   input  wire logic                   lsb_sync_req,
   input  wire logic                   sysref_req
);

   // ==========================================================
   // lead of the lsb marker, in frames
   // ==========================================================
   logic [11:0] lead_frames;
   logic [11:0] lead_count;
   logic        lead_armed;
   logic        mark_now;
   int          lead;
   int          spf;

   always_comb begin
      spf  = int'(samples_per_frame(link_format_select));
      lead = lsb_sync_offset(interpolation_factor, 4'h0);
      if (lead < 0 || spf == 0 || interpolation_factor == 9'h000)
         lead = 0;
      else
         lead = lead / int'(interpolation_factor) / spf;
      lead_frames = 12'(lead);
   end

   assign mark_now = lead_armed && lead_count == '0;

   // ==========================================================
   // packing
   // ==========================================================
   lane_t lanes [LANE_COUNT];

   always_comb begin
      logic [47:0] gi;
      logic [47:0] gq;
      sample_t     i0;
      gi = '0;
      gq = '0;
      // the marker rides on the lsb of the word actually sent
      if (link_format_select >= FMT_8B_16L)
         i0 = {tx_inphase[0][11:5], mark_now, 4'h0};
      else
         i0 = {tx_inphase[0][11:1], mark_now};
      for (int l = 0; l < LANE_COUNT; l++)
         lanes[l] = '0;
      unique case (link_format_select)
         FMT_12B_6L, FMT_12B_3L: begin
            for (int g = 0; g < 2; g++) begin
               gi = {(g == 0) ? i0 : tx_inphase[4*g], tx_inphase[4*g+1], tx_inphase[4*g+2], tx_inphase[4*g+3]};
               gq = {tx_quadrature[4*g], tx_quadrature[4*g+1], tx_quadrature[4*g+2], tx_quadrature[4*g+3]};
               for (int m = 0; m < 3; m++) begin
                  lanes[3*g+m][63:48] = gi[47-16*m -: 16];
                  if (link_format_select == FMT_12B_6L)
                     lanes[3*g+m+6][63:48] = gq[47-16*m -: 16];
               end
            end
         end
         FMT_12B_4L: begin
            for (int k = 0; k < 4; k++) begin
               for (int j = 0; j < 5; j++) begin
                  lanes[k][63-12*j -: 12]   = (k + 4*j == 0) ? i0 : tx_inphase[k+4*j];
                  lanes[k+4][63-12*j -: 12] = tx_quadrature[k+4*j];
               end
            end
         end
         FMT_8B_16L: begin
            lanes[0][63:56] = i0[11:4];
            for (int n = 1; n < 16; n++)
               lanes[n][63:56] = tx_inphase[n][11:4];
         end
         FMT_8B_8L, FMT_8B_4L: begin
            for (int n = 0; n < 8; n++) begin
               if (link_format_select == FMT_8B_8L || n < 4) begin
                  lanes[n][63:56] = (n == 0) ? i0[11:4] : tx_inphase[n][11:4];
                  lanes[(link_format_select == FMT_8B_8L) ? n+8 : n+4][63:56] = tx_quadrature[n][11:4];
               end
            end
         end
         default: lanes[0] = '0;
      endcase
   end

   // ==========================================================
   // frame register and link handshake
   // ==========================================================
   logic take;
   assign take = tx_valid & tx_ready;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         link.frame_valid <= 1'b0;
         tx_ready         <= 1'b1;
         link.mf_phase    <= '0;
         for (int l = 0; l < LANE_COUNT; l++)
            link.lane_data[l] <= '0;
      end else if (take) begin
         link.lane_data   <= lanes;
         link.frame_valid <= 1'b1;
         tx_ready         <= 1'b0;
      end else if (link.frame_valid && link.frame_ready) begin
         link.frame_valid <= 1'b0;
         tx_ready         <= 1'b1;
         link.mf_phase    <= 4'(int'(link.mf_phase) + 1);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         lead_armed <= 1'b0;
         lead_count <= '0;
      end else if (lsb_sync_req && !lead_armed) begin
         lead_armed <= 1'b1;
         lead_count <= lead_frames;
      end else if (take) begin
         if (mark_now)
            lead_armed <= 1'b0;
         else if (lead_armed)
            lead_count <= lead_count - 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         link.sysref <= 1'b0;
      else
         link.sysref <= sysref_req;
   end

endmodule // lane_sample_packer

// [src/lane_sample_unpacker.sv]
// Purpose: receive end; lane frames to in-phase and quadrature samples, oscillator sync
// Assumes: transmitter packs lanes per link_format_select; sysref arrives over the link from the transmitter
// Notes:   8-bit samples are left justified in the 12-bit sample words
`timescale 1ns/10ps
module lane_sample_unpacker
   import lane_unpack_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   rst_b,
   lane_link_if.rx                     link,
   input  wire logic [4:0]             link_format_select,
   input  wire logic                   sync_source_sel,
   input  wire logic [8:0]             interpolation_factor,
   input  wire logic [1:0]             sync_action,
   output logic      [SAMPLE_BITS-1:0] chan0_inphase_sample    [MAX_SAMPLES],
   output logic      [SAMPLE_BITS-1:0] chan0_quadrature_sample [MAX_SAMPLES],
   output logic      [COUNT_BITS-1:0]  sample_count,
   output logic                        sample_valid,
   input  wire logic                   sample_ready,
   output logic                        nco_sync_pulse,
   output logic      [1:0]             nco_sync_action
);

   // ==========================================================
   // unpacking
   // ==========================================================
   sample_t               new_i [MAX_SAMPLES];
   sample_t               new_q [MAX_SAMPLES];
   logic [COUNT_BITS-1:0] new_count;

   function automatic logic [47:0] group3(input lane_t a, input lane_t b, input lane_t c);
      return {a[63:48], b[63:48], c[63:48]};
   endfunction

   always_comb begin
      logic [47:0] gi;
      logic [47:0] gq;
      gi = '0;
      gq = '0;
      for (int s = 0; s < MAX_SAMPLES; s++) begin
         new_i[s] = '0;
         new_q[s] = '0;
      end
      new_count = samples_per_frame(link_format_select);
      unique case (link_format_select)
         FMT_12B_6L, FMT_12B_3L: begin
            for (int g = 0; g < 2; g++) begin
               gi = group3(link.lane_data[3*g], link.lane_data[3*g+1], link.lane_data[3*g+2]);
               gq = group3(link.lane_data[3*g+6], link.lane_data[3*g+7], link.lane_data[3*g+8]);
               for (int s = 0; s < 4; s++) begin
                  new_i[4*g+s] = gi[47-12*s -: 12];
                  if (link_format_select == FMT_12B_6L)
                     new_q[4*g+s] = gq[47-12*s -: 12];
               end
            end
         end
         FMT_12B_4L: begin
            for (int k = 0; k < 4; k++) begin
               for (int j = 0; j < 5; j++) begin
                  new_i[k+4*j] = link.lane_data[k][63-12*j -: 12];
                  new_q[k+4*j] = link.lane_data[k+4][63-12*j -: 12];
               end
            end
         end
         FMT_8B_16L: begin
            for (int n = 0; n < 16; n++)
               new_i[n] = {link.lane_data[n][63:56], 4'h0};
         end
         FMT_8B_8L: begin
            for (int n = 0; n < 8; n++) begin
               new_i[n] = {link.lane_data[n][63:56], 4'h0};
               new_q[n] = {link.lane_data[n+8][63:56], 4'h0};
            end
         end
         FMT_8B_4L: begin
            for (int n = 0; n < 4; n++) begin
               new_i[n] = {link.lane_data[n][63:56], 4'h0};
               new_q[n] = {link.lane_data[n+4][63:56], 4'h0};
            end
         end
         default: new_count = '0;
      endcase
   end

   // ==========================================================
   // two-entry buffer: output stage plus skid stage
   // ==========================================================
   sample_t               skid_i [MAX_SAMPLES];
   sample_t               skid_q [MAX_SAMPLES];
   logic [COUNT_BITS-1:0] skid_count;
   logic                  skid_free;
   logic                  accept;
   logic                  push;
   logic                  pop;

   assign link.frame_ready = skid_free;
   assign accept           = link.frame_valid & skid_free;
   assign push             = accept & (new_count != '0);
   assign pop              = sample_valid & sample_ready;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sample_valid <= 1'b0;
         skid_free    <= 1'b1;
         sample_count <= '0;
         skid_count   <= '0;
         for (int s = 0; s < MAX_SAMPLES; s++) begin
            chan0_inphase_sample[s]    <= '0;
            chan0_quadrature_sample[s] <= '0;
            skid_i[s]                  <= '0;
            skid_q[s]                  <= '0;
         end
      end else if (pop || !sample_valid) begin
         if (!skid_free) begin
            chan0_inphase_sample    <= skid_i;
            chan0_quadrature_sample <= skid_q;
            sample_count            <= skid_count;
            sample_valid            <= 1'b1;
            skid_free               <= 1'b1;
         end else if (push) begin
            chan0_inphase_sample    <= new_i;
            chan0_quadrature_sample <= new_q;
            sample_count            <= new_count;
            sample_valid            <= 1'b1;
         end else begin
            sample_valid <= 1'b0;
         end
      end else if (push) begin
         skid_i     <= new_i;
         skid_q     <= new_q;
         skid_count <= new_count;
         skid_free  <= 1'b0;
      end
   end

   // ==========================================================
   // sysref synchronizer
   // ==========================================================
   logic sysref_meta;
   logic sysref_sync;
   logic sysref_prev;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sysref_meta <= 1'b0;
         sysref_sync <= 1'b0;
         sysref_prev <= 1'b0;
      end else begin
         sysref_meta <= link.sysref;
         sysref_sync <= sysref_meta;
         sysref_prev <= sysref_sync;
      end
   end

   // ==========================================================
   // oscillator sync delay
   // ==========================================================
   logic                       lsb_prev;
   logic                       lsb_bit;
   logic                       lsb_rise;
   logic                       sysref_rise;
   logic                       sync_armed;
   logic [SYNC_COUNT_BITS-1:0] sync_count;
   logic [SYNC_COUNT_BITS-1:0] lsb_delay;
   int                         lsb_total;

   // 8-bit words are left justified, so their lsb sits at bit 4
   assign lsb_bit     = (link_format_select >= FMT_8B_16L) ? new_i[0][4] : new_i[0][0];
   assign lsb_rise    = push & lsb_bit & ~lsb_prev;
   assign sysref_rise = sysref_sync & ~sysref_prev;

   always_comb begin
      lsb_total = lsb_sync_offset(interpolation_factor, link.mf_phase) + LSB_PATH_BIAS;
      if (lsb_total < 1)
         lsb_total = 1;
      lsb_delay = SYNC_COUNT_BITS'(lsb_total - 1);
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b)
         lsb_prev <= 1'b0;
      else if (push)
         lsb_prev <= lsb_bit;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sync_armed      <= 1'b0;
         sync_count      <= '0;
         nco_sync_pulse  <= 1'b0;
         nco_sync_action <= SYNC_FREQ_CHANGE;
      end else begin
         nco_sync_pulse <= 1'b0;
         if (sync_source_sel && sysref_rise) begin
            sync_armed      <= 1'b1;
            sync_count      <= SYNC_COUNT_BITS'(SYSREF_SYNC_CYCLES - 3);
            nco_sync_action <= sync_action;
         end else if (!sync_source_sel && lsb_rise) begin
            sync_armed      <= 1'b1;
            sync_count      <= lsb_delay;
            nco_sync_action <= sync_action;
         end else if (sync_armed) begin
            if (sync_count == '0) begin
               sync_armed     <= 1'b0;
               nco_sync_pulse <= 1'b1;
            end else begin
               sync_count <= sync_count - 1'b1;
            end
         end
      end
   end

endmodule // lane_sample_unpacker

// [tb/lane_link_sva.sv]
// Purpose: handshake and multiframe checks on the lane link
// Assumes: one clock domain, clk_sys, reset rst_b
// Notes:   sees the interface signals only
`timescale 1ns/10ps
module lane_link_sva
   import lane_unpack_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rst_b,
   input wire lane_t      lane_data [LANE_COUNT],
   input wire logic       frame_valid,
   input wire logic       frame_ready,
   input wire logic [3:0] mf_phase,
   input wire logic       sysref
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   wire take = frame_valid && frame_ready;
   // ==========================================================
   // frame handshake
   // ==========================================================
   valid_hold_a: assert property (frame_valid && !frame_ready |=> frame_valid)
      else $error("frame withdrawn before taken");
   data_hold_a: assert property (frame_valid && !frame_ready |=> $stable(lane_data[0]) && $stable(lane_data[15]))
      else $error("lane data changed while offered");
   frame_gap_a: assert property (take |=> !frame_valid)
      else $error("frame offered right after a take");
   no_withdraw_a: assert property ($fell(frame_valid) |-> $past(frame_ready))
      else $error("valid fell without a take");
   ready_fall_a: assert property ($fell(frame_ready) |-> $past(take))
      else $error("ready fell without a take");
   // ==========================================================
   // multiframe index
   // ==========================================================
   phase_step_a: assert property (take |=> mf_phase == $past(mf_phase) + 4'h1)
      else $error("frame index did not advance");
   phase_hold_a: assert property (!take |=> $stable(mf_phase))
      else $error("frame index moved without a take");
   phase_wrap_a: assert property (take && mf_phase == 4'hf |=> mf_phase == 4'h0)
      else $error("frame index did not wrap");
   cover property (take);
   cover property (frame_valid && !frame_ready);
   cover property ($rose(sysref));
endmodule // lane_link_sva

// [tb/tb_top.sv]
// Purpose: packer and unpacker back to back; samples, lanes, sync timing
// Assumes: clk_sys 25 MHz; rst_b low for 3 cycles
// Notes:   expected values are rebuilt from the lane maps
`timescale 1ns/10ps
module tb_top;
   import lane_unpack_pkg::*;
   logic       clk_sys, rst_b, tx_valid, tx_ready, lsb_req, sys_req, src_sel, s_rdy, rx_val, nco_p;
   logic [4:0] link_format_select, rx_cnt;
   logic [8:0] interpolation_factor;
   logic [1:0] act, nco_a;
   sample_t    tx_i [MAX_SAMPLES], tx_q [MAX_SAMPLES], rx_i [MAX_SAMPLES], rx_q [MAX_SAMPLES];
   int         n_fail, n_compared, cyc, t_mark, t_pulse, mark_k;
   logic       last_mark;
   lane_link_if link();
   lane_sample_packer u_lane_sample_packer (.clk_sys, .rst_b, .link(link), .link_format_select,
      .interpolation_factor, .tx_inphase(tx_i), .tx_quadrature(tx_q), .tx_valid, .tx_ready,
      .lsb_sync_req(lsb_req), .sysref_req(sys_req));
   lane_sample_unpacker u_lane_sample_unpacker (.clk_sys, .rst_b, .link(link), .link_format_select,
      .sync_source_sel(src_sel), .interpolation_factor, .sync_action(act), .chan0_inphase_sample(rx_i),
      .chan0_quadrature_sample(rx_q), .sample_count(rx_cnt), .sample_valid(rx_val), .sample_ready(s_rdy),
      .nco_sync_pulse(nco_p), .nco_sync_action(nco_a));
   lane_link_sva u_lane_link_sva (.clk_sys, .rst_b, .lane_data(link.lane_data), .frame_valid(link.frame_valid),
      .frame_ready(link.frame_ready), .mf_phase(link.mf_phase), .sysref(link.sysref));
   initial begin
      clk_sys = 1'b0;
      forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
   end
   // marked frame takes and sync pulses, stamped in cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (nco_p === 1'b1) t_pulse <= cyc;
      if (link.frame_valid && link.frame_ready) begin
         last_mark <= link.lane_data[0][52];
         if (link.lane_data[0][52] && !last_mark) t_mark <= cyc;
      end
   end
   // ==========================================================
   // helpers
   // ==========================================================
   task automatic chk(input logic [15:0] got, exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_dly(input int got, exp, input string what);
      n_compared++;
      if (got != exp) begin
         n_fail++;
         $display("[ERR] %0t %s delay %0d exp %0d", $time, what, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   function automatic int cnt(input logic [4:0] f);
      case (f)
         FMT_12B_4L: return 20;
         FMT_8B_16L: return 16;
         FMT_8B_4L:  return 4;
         default:    return 8;
      endcase
   endfunction
   // sample 0 in-phase keeps its sync bits clear
   function automatic sample_t gen(input int j, q, k);
      sample_t s;
      s = sample_t'((q ? 12'h5a3 : 12'h0b7) * (j + 1) + k * 12'h111);
      return (j == 0 && q == 0) ? s & 12'hfee : s;
   endfunction
   function automatic sample_t ex(input int j, q, k);
      sample_t s;
      s = gen(j, q, k);
      if (j >= cnt(link_format_select)) return 12'h000;
      if (q != 0 && (link_format_select inside {FMT_12B_3L, FMT_8B_16L})) return 12'h000;
      return (link_format_select >= FMT_8B_16L) ? {s[11:4], 4'h0} : s;
   endfunction
   task automatic wire_chk(input int k);
      sample_t a, b, c, d;
      int      per;
      per = (link_format_select == FMT_8B_16L) ? 16 : (link_format_select == FMT_8B_8L ? 8 : 4);
      for (int n = 0; n < LANE_COUNT; n++) begin
         case (link_format_select)
            FMT_12B_6L, FMT_12B_3L: if (n % 3 == 0 && n < (link_format_select == FMT_12B_3L ? 6 : 12)) begin
               a = gen(4 * ((n / 3) % 2), n / 6, k);
               b = gen(4 * ((n / 3) % 2) + 1, n / 6, k);
               c = gen(4 * ((n / 3) % 2) + 2, n / 6, k);
               d = gen(4 * ((n / 3) % 2) + 3, n / 6, k);
               if (n == 0 && k == mark_k) a[0] = 1'b1;
               chk(link.lane_data[n][63:48], {a, b[11:8]}, "lane1");
               chk(link.lane_data[n+1][63:48], {b[7:0], c[11:4]}, "lane2");
               chk(link.lane_data[n+2][63:48], {c[3:0], d}, "lane3");
            end
            FMT_12B_4L: if (n < 8) begin
               for (int j = 0; j < 5; j++) begin
                  chk(16'(link.lane_data[n][63-12*j -: 12]), 16'(gen(n % 4 + 4 * j, n / 4, k)), "lane12");
               end
            end
            default: if (n < (per == 16 ? 16 : 2 * per)) begin
               a = gen(n % per, n / per, k);
               chk(16'(link.lane_data[n][63:56]), 16'(a[11:4]), "lane8");
            end
         endcase
      end
   endtask
   task automatic send(input int k);
      int w;
      w = 0;
      @(posedge clk_sys);
      for (int j = 0; j < MAX_SAMPLES; j++) begin
         tx_i[j] <= gen(j, 0, k);
         tx_q[j] <= gen(j, 1, k);
      end
      tx_valid <= 1'b1;
      do @(posedge clk_sys); while (tx_ready !== 1'b1 && ++w < 100);
      tx_valid <= 1'b0;
      @(negedge clk_sys);
      wire_chk(k);
   endtask
   task automatic recv(input int k);
      int w;
      w = 0;
      do @(negedge clk_sys); while (rx_val !== 1'b1 && ++w < 50);
      chk(16'(rx_val), 16'h0001, "valid");
      chk(16'(rx_cnt), 16'(cnt(link_format_select)), "count");
      for (int j = 0; j < MAX_SAMPLES; j++) begin
         chk(16'(rx_i[j]), 16'(ex(j, 0, k)), "inphase");
         chk(16'(rx_q[j]), 16'(ex(j, 1, k)), "quadrature");
      end
      @(posedge clk_sys);
   endtask
   task automatic wait_pulse;
      for (int w = 0; w < 1500 && t_pulse < 0; w++) @(posedge clk_sys);
   endtask
   // ==========================================================
   // tests
   // ==========================================================
   initial begin
      logic [4:0] fmts [6] = '{FMT_12B_6L, FMT_12B_4L, FMT_12B_3L, FMT_8B_16L, FMT_8B_8L, FMT_8B_4L};
      int         offs [2] = '{290, 648};
      {rst_b, tx_valid, lsb_req, sys_req, src_sel, last_mark, act} = '0;
      {n_fail, n_compared, cyc} = '0;
      t_mark = -1;
      t_pulse = -1;
      // lsb lead: 290/16 or 648/32 samples, eight a frame, marks the third frame sent
      mark_k = 22;
      s_rdy = 1'b1;
      link_format_select = FMT_12B_6L;
      interpolation_factor = 9'h010;
      for (int j = 0; j < MAX_SAMPLES; j++) {tx_i[j], tx_q[j]} = '0;
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      foreach (fmts[f]) begin
         link_format_select <= fmts[f];
         send(f);
         recv(f);
      end
      $display("test formats done");
      s_rdy <= 1'b0;
      for (int k = 10; k < 13; k++) send(k);
      repeat (4) @(negedge clk_sys);
      chk(16'(link.frame_ready), 16'h0000, "stall ready");
      chk(16'(link.frame_valid), 16'h0001, "stall valid");
      @(posedge clk_sys);
      s_rdy <= 1'b1;
      for (int k = 10; k < 13; k++) recv(k);
      @(negedge clk_sys);
      chk(16'(rx_val), 16'h0000, "drained");
      $display("test stall done");
      for (int a = 0; a < 2; a++) begin
         @(posedge clk_sys);
         t_pulse = -1;
         src_sel <= 1'b1;
         act <= 2'(a);
         sys_req <= 1'b1;
         t_mark = cyc;
         @(posedge clk_sys);
         sys_req <= 1'b0;
         wait_pulse();
         chk_dly(t_pulse - t_mark, SYSREF_SYNC_CYCLES + 3, "sysref");
         chk(16'(nco_a), 16'(a), "action");
      end
      $display("test sysref done");
      foreach (offs[i]) begin
         t_mark = -1;
         t_pulse = -1;
         @(posedge clk_sys);
         src_sel <= 1'b0;
         link_format_select <= FMT_12B_6L;
         act <= 2'h2;
         interpolation_factor <= 9'(i == 0 ? 16 : 32);
         lsb_req <= 1'b1;
         @(posedge clk_sys);
         lsb_req <= 1'b0;
         for (int k = 20; k < 28; k++) send(k);
         wait_pulse();
         chk_dly(t_pulse - t_mark, offs[i] + LSB_PATH_BIAS + 1, "lsb");
         chk(16'(nco_a), 16'h0002, "action");
      end
      $display("test lsb done");
      tally_and_finish();
   end
   initial begin
      #(CLK_PERIOD_NS * 20000);
      n_fail++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule // tb_top
